// ### casb_pkg.sv
/*
 * Package for the command agent status bank: register offsets, agent field
 * layout, state encodings and interrupt status width.
 * Assumes a 32-bit register port with one-cycle read latency.
 */
package casb_pkg;
   localparam int          CASB_NUM_AGENTS   = 4;
   localparam int          CASB_GROUP_W      = 8;
   localparam logic [7:0]  CASB_ADDR_CTRL    = 8'h50;
   localparam logic [7:0]  CASB_ADDR_STATUS  = 8'h5c;
   localparam logic [7:0]  CASB_ADDR_IRQ_ST  = 8'h80;
   localparam logic [7:0]  CASB_ADDR_IRQ_MSK = 8'h84;
   localparam logic [31:0] CASB_STATUS_RST   = 32'h0000_0000;
   localparam logic [31:0] CASB_CTRL_RST     = 32'h0000_0000;
   localparam logic [7:0]  CASB_IRQ_RST      = 8'h00;
   // Field positions inside an agent group
   localparam int          CASB_F_STATE_LO   = 0;
   localparam int          CASB_F_DOORBELL   = 2;
   localparam int          CASB_F_UNSOL      = 3;
   localparam int          CASB_F_DEAD       = 4;
   localparam int          CASB_F_RSTSTATE   = 5;
   localparam int          CASB_F_DBCLR      = 6;
   localparam int          CASB_F_USCLR      = 7;
   // Agent control register fields
   localparam int          CASB_C_SEL_LO     = 0;
   localparam int          CASB_C_AUTOCLR    = 11;
   // tLabel pattern for automatic clear
   localparam logic [2:0]  CASB_TL_PREFIX    = 3'h7;
   localparam int          CASB_IRQ_W        = 8;

   typedef enum logic [1:0]
   {
      CASB_ST_RESET     = 2'b00,
      CASB_ST_ACTIVE    = 2'b01,
      CASB_ST_SUSPENDED = 2'b10,
      CASB_ST_DEAD      = 2'b11
   } casb_state_type;
endpackage

// ### casb_agent.sv
/*
 * One command block agent: state field, doorbell and unsolicited-enable flags.
 * Assumes single-cycle pulse inputs on the system clock and a synchronous
 * bus-reset pulse.
 */
`timescale 1ns/1ps
module casb_agent
   import casb_pkg::*;
(
   input  wire logic           sys_clk_i,
   input  wire logic           rst_n_i,
   input  wire logic           bus_reset_i,
   input  wire logic           doorbell_wr_i,
   input  wire logic           unsol_wr_i,
   input  wire logic           auto_clear_i,
   input  wire logic           force_dead_i,
   input  wire logic           force_reset_state_i,
   input  wire logic           doorbell_flag_clear_i,
   input  wire logic           unsol_flag_clear_i,
   input  wire logic           state_valid_i,
   input  wire casb_state_type state_i,
   output casb_state_type      agent_state_o,
   output logic                doorbell_flag_o,
   output logic                unsol_enable_flag_o
);
   casb_state_type state_q;
   logic           doorbell_q;
   logic           unsol_q;

   // State field updates
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         state_q <= CASB_ST_RESET;
      else if (bus_reset_i)
         state_q <= CASB_ST_RESET;
      else if (force_dead_i)
         state_q <= CASB_ST_DEAD;
      else if (force_reset_state_i)
         state_q <= CASB_ST_RESET;
      else if (state_valid_i)
         state_q <= state_i;
   end

   // Doorbell flag: set wins over clear
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         doorbell_q <= 1'b0;
      else if (bus_reset_i)
         doorbell_q <= 1'b0;
      else if (doorbell_wr_i)
         doorbell_q <= 1'b1;
      else if (doorbell_flag_clear_i)
         doorbell_q <= 1'b0;
   end

   // Unsolicited-enable flag: set wins over clear
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         unsol_q <= 1'b0;
      else if (bus_reset_i)
         unsol_q <= 1'b0;
      else if (unsol_wr_i)
         unsol_q <= 1'b1;
      else if (unsol_flag_clear_i || auto_clear_i)
         unsol_q <= 1'b0;
   end

   assign agent_state_o       = state_q;
   assign doorbell_flag_o     = doorbell_q;
   assign unsol_enable_flag_o = unsol_q;
endmodule

// ### casb_bank.sv
/*
 * Agent status register bank for four command block agents, with agent
 * control bits and a masked interrupt on doorbell and unsolicited-enable events.
 * Assumes a simple strobe register port and event pulses on sys_clk_i.
 */
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps

module casb_bank
   import casb_pkg::*;
#(
   parameter int NUM_AGENTS = CASB_NUM_AGENTS
)
(
   input  wire logic        sys_clk_i,
   input  wire logic        resetn_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic [31:0]      rdata_o,
   input  wire logic        bus_reset_i,
   input  wire logic [3:0]  doorbell_wr_i,
   input  wire logic [3:0]  unsol_wr_i,
   input  wire logic        tx_done_i,
   input  wire logic [5:0]  tx_tlabel_i,
   input  wire logic [3:0]  state_valid_i,
   input  wire logic [7:0]  state_i,
   output logic             irq_o
);
   logic [1:0]                 rst_sync_q;
   logic                       rst_n;
   logic [31:0]                ctrl_q;
   logic [31:0]                rdata_q;
   logic [CASB_IRQ_W-1:0]      irq_st_q;
   logic [CASB_IRQ_W-1:0]      irq_msk_q;
   logic                       irq_q;
   logic                       wr_status;
   logic                       rd_irq;
   logic [31:0]                status;
   logic [NUM_AGENTS-1:0]      db_flag;
   logic [NUM_AGENTS-1:0]      us_flag;
   logic [NUM_AGENTS-1:0]      auto_clr;
   logic [CASB_IRQ_W-1:0]      irq_ev;
   logic [1:0]                 sel;

   // Reset release through two flip-flops
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         rst_sync_q <= 2'b00;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   assign wr_status = wr_i && (addr_i == CASB_ADDR_STATUS);
   assign rd_irq    = rd_i && (addr_i == CASB_ADDR_IRQ_ST);
   assign sel       = ctrl_q[CASB_C_SEL_LO +: 2];

   // Agent control register
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_q <= CASB_CTRL_RST;
      else if (wr_i && addr_i == CASB_ADDR_CTRL)
         ctrl_q <= wdata_i;
   end

   genvar g;
   generate
      for (g = 0; g < NUM_AGENTS; g++)
      begin : g_agent
         casb_state_type st;
         // Auto clear on matching tLabel when enabled
         assign auto_clr[g] = ctrl_q[CASB_C_AUTOCLR] && tx_done_i
                            && tx_tlabel_i[5:3] == CASB_TL_PREFIX
                            && tx_tlabel_i[2:1] == sel && sel == 2'(g);
         casb_agent u_agent
         (
            .sys_clk_i             (sys_clk_i),
            .rst_n_i               (rst_n),
            .bus_reset_i           (bus_reset_i),
            .doorbell_wr_i         (doorbell_wr_i[g]),
            .unsol_wr_i            (unsol_wr_i[g]),
            .auto_clear_i          (auto_clr[g]),
            .force_dead_i          (wr_status && wdata_i[g*CASB_GROUP_W+CASB_F_DEAD]),
            .force_reset_state_i   (wr_status && wdata_i[g*CASB_GROUP_W+CASB_F_RSTSTATE]),
            .doorbell_flag_clear_i (wr_status && wdata_i[g*CASB_GROUP_W+CASB_F_DBCLR]),
            .unsol_flag_clear_i    (wr_status && wdata_i[g*CASB_GROUP_W+CASB_F_USCLR]),
            .state_valid_i         (state_valid_i[g]),
            .state_i               (casb_state_type'(state_i[2*g +: 2])),
            .agent_state_o         (st),
            .doorbell_flag_o       (db_flag[g]),
            .unsol_enable_flag_o   (us_flag[g])
         );
         // Control bits read zero since they self-clear
         assign status[g*CASB_GROUP_W +: CASB_GROUP_W] =
            {4'h0, us_flag[g], db_flag[g], st};
      end
   endgenerate

   // Events: doorbell sets in low nibble, unsol sets in high nibble
   assign irq_ev = {unsol_wr_i, doorbell_wr_i};

   // Sticky status: set wins over read clear
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         irq_st_q <= CASB_IRQ_RST;
      else if (rd_irq)
         irq_st_q <= irq_ev;
      else
         irq_st_q <= irq_st_q | irq_ev;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         irq_msk_q <= CASB_IRQ_RST;
      else if (wr_i && addr_i == CASB_ADDR_IRQ_MSK)
         irq_msk_q <= wdata_i[CASB_IRQ_W-1:0];
   end

   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         irq_q <= 1'b0;
      else
         irq_q <= |(irq_st_q & irq_msk_q);
   end

   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         rdata_q <= CASB_STATUS_RST;
      else if (!rd_i)
         rdata_q <= CASB_STATUS_RST;
      else
      begin
         unique case (addr_i)
            CASB_ADDR_CTRL:    rdata_q <= ctrl_q;
            CASB_ADDR_STATUS:  rdata_q <= status;
            CASB_ADDR_IRQ_ST:  rdata_q <= {24'h0, irq_st_q};
            CASB_ADDR_IRQ_MSK: rdata_q <= {24'h0, irq_msk_q};
            default:           rdata_q <= CASB_STATUS_RST;
         endcase
      end
   end

   assign rdata_o = rdata_q;
   assign irq_o   = irq_q;

   property p_doorbell_set;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (doorbell_wr_i[0] && !bus_reset_i) |=> db_flag[0];
   endproperty
   a_doorbell_set: assert property (p_doorbell_set) else $error("doorbell not set");

   property p_doorbell_clr;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (wr_status && wdata_i[CASB_F_DBCLR] && !doorbell_wr_i[0]) |=> !db_flag[0];
   endproperty
   a_doorbell_clr: assert property (p_doorbell_clr) else $error("doorbell not cleared");

   property p_unsol_set;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (unsol_wr_i[1] && !bus_reset_i) |=> us_flag[1];
   endproperty
   a_unsol_set: assert property (p_unsol_set) else $error("unsol not set");

   property p_unsol_clr;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (wr_status && wdata_i[CASB_F_USCLR] && !unsol_wr_i[0]) |=> !us_flag[0];
   endproperty
   a_unsol_clr: assert property (p_unsol_clr) else $error("unsol not cleared");

   property p_auto_off;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (!ctrl_q[CASB_C_AUTOCLR] && !bus_reset_i && !wr_status && us_flag[0]) |=> us_flag[0];
   endproperty
   a_auto_off: assert property (p_auto_off) else $error("unsol lost with auto clear off");

   property p_auto_on;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (ctrl_q[CASB_C_AUTOCLR] && tx_done_i && tx_tlabel_i == 6'h38 && sel == 2'b00 && !unsol_wr_i[0])
      |=> !us_flag[0];
   endproperty
   a_auto_on: assert property (p_auto_on) else $error("auto clear missed");

   property p_dead;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (wr_status && wdata_i[CASB_F_DEAD] && !bus_reset_i) |=> status[1:0] == CASB_ST_DEAD;
   endproperty
   a_dead: assert property (p_dead) else $error("force dead failed");

   property p_busreset;
      @(posedge sys_clk_i) disable iff (!rst_n)
      bus_reset_i |=> status == CASB_STATUS_RST;
   endproperty
   a_busreset: assert property (p_busreset) else $error("bus reset did not clear");

   property p_selfclr;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (wr_status && !bus_reset_i && !doorbell_wr_i[0] && !unsol_wr_i[0] && !state_valid_i[0] && !auto_clr[0]
       && wdata_i[CASB_F_DEAD +: 4] == 4'h0) |=> $stable(status[CASB_GROUP_W-1:0]);
   endproperty
   a_selfclr: assert property (p_selfclr) else $error("read-only bits changed by a write");

   property p_doorbell_set_all;
      @(posedge sys_clk_i) disable iff (!rst_n)
      !bus_reset_i |=> (db_flag & $past(doorbell_wr_i)) == $past(doorbell_wr_i);
   endproperty
   a_doorbell_set_all: assert property (p_doorbell_set_all) else $error("doorbell not set for an agent");

   property p_unsol_set_all;
      @(posedge sys_clk_i) disable iff (!rst_n)
      !bus_reset_i |=> (us_flag & $past(unsol_wr_i)) == $past(unsol_wr_i);
   endproperty
   a_unsol_set_all: assert property (p_unsol_set_all) else $error("unsol not set for an agent");

   property p_state_load;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (state_valid_i[2] && !bus_reset_i && !wr_status) |=> status[2*CASB_GROUP_W +: 2] == $past(state_i[5:4]);
   endproperty
   a_state_load: assert property (p_state_load) else $error("state load lost");

   property p_force_reset;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (wr_status && wdata_i[CASB_F_RSTSTATE] && !wdata_i[CASB_F_DEAD] && !bus_reset_i) |=> status[1:0] == CASB_ST_RESET;
   endproperty
   a_force_reset: assert property (p_force_reset) else $error("force reset failed");

   property p_dead_last;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (wr_status && wdata_i[3*CASB_GROUP_W+CASB_F_DEAD] && !bus_reset_i) |=> status[3*CASB_GROUP_W +: 2] == CASB_ST_DEAD;
   endproperty
   a_dead_last: assert property (p_dead_last) else $error("force dead failed on last agent");

   property p_auto_other;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (ctrl_q[CASB_C_AUTOCLR] && tx_done_i && sel != 2'b01 && !bus_reset_i && !wr_status && us_flag[1]) |=> us_flag[1];
   endproperty
   a_auto_other: assert property (p_auto_other) else $error("auto clear hit an unselected agent");

   property p_auto_agent2;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (ctrl_q[CASB_C_AUTOCLR] && tx_done_i && tx_tlabel_i[5:1] == {CASB_TL_PREFIX, 2'b10} && sel == 2'b10
       && !unsol_wr_i[2]) |=> !us_flag[2];
   endproperty
   a_auto_agent2: assert property (p_auto_agent2) else $error("auto clear missed on agent 2");

   property p_auto_prefix;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (tx_tlabel_i[5:3] != CASB_TL_PREFIX && !bus_reset_i && !wr_status && us_flag[2]) |=> us_flag[2];
   endproperty
   a_auto_prefix: assert property (p_auto_prefix) else $error("unsol cleared by foreign label");

   property p_auto_off_agent2;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (!ctrl_q[CASB_C_AUTOCLR] && tx_done_i && !bus_reset_i && !wr_status && us_flag[2]) |=> us_flag[2];
   endproperty
   a_auto_off_agent2: assert property (p_auto_off_agent2) else $error("unsol cleared with auto clear off");

   property p_doorbell_hold;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (db_flag[3] && !bus_reset_i && !(wr_status && wdata_i[3*CASB_GROUP_W+CASB_F_DBCLR])) |=> db_flag[3];
   endproperty
   a_doorbell_hold: assert property (p_doorbell_hold) else $error("doorbell lost without clear");

   property p_unsol_clr_agent2;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (wr_status && wdata_i[2*CASB_GROUP_W+CASB_F_USCLR] && !unsol_wr_i[2]) |=> !us_flag[2];
   endproperty
   a_unsol_clr_agent2: assert property (p_unsol_clr_agent2) else $error("unsol not cleared on agent 2");

   property p_unsol_hold;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (us_flag[3] && !bus_reset_i && !auto_clr[3] && !(wr_status && wdata_i[3*CASB_GROUP_W+CASB_F_USCLR]))
      |=> us_flag[3];
   endproperty
   a_unsol_hold: assert property (p_unsol_hold) else $error("unsol lost without clear");

   property p_state_hold;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (!bus_reset_i && !wr_status && !state_valid_i[1]) |=> $stable(status[CASB_GROUP_W +: 2]);
   endproperty
   a_state_hold: assert property (p_state_hold) else $error("state changed with no cause");

   property p_ctrl_keep;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (bus_reset_i && !(wr_i && addr_i == CASB_ADDR_CTRL)) |=> $stable(ctrl_q);
   endproperty
   a_ctrl_keep: assert property (p_ctrl_keep) else $error("control changed by bus reset");

   property p_ctrl_write;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (wr_i && addr_i == CASB_ADDR_CTRL) |=> sel == $past(wdata_i[1:0]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("agent select not written");

   property p_status_read;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (rd_i && addr_i == CASB_ADDR_STATUS) |=> rdata_o == $past(status);
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read data wrong");

   property p_ctrl_read;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (rd_i && addr_i == CASB_ADDR_CTRL) |=> rdata_o == $past(ctrl_q);
   endproperty
   a_ctrl_read: assert property (p_ctrl_read) else $error("control read data wrong");

   property p_unmapped_read;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (rd_i && addr_i != CASB_ADDR_CTRL && addr_i != CASB_ADDR_STATUS && addr_i != CASB_ADDR_IRQ_ST
       && addr_i != CASB_ADDR_IRQ_MSK) |=> rdata_o == CASB_STATUS_RST;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

   property p_irq_doorbell;
      @(posedge sys_clk_i) disable iff (!rst_n)
      doorbell_wr_i[0] |=> irq_st_q[0];
   endproperty
   a_irq_doorbell: assert property (p_irq_doorbell) else $error("doorbell event lost");

   property p_irq_unsol;
      @(posedge sys_clk_i) disable iff (!rst_n)
      unsol_wr_i[3] |=> irq_st_q[CASB_NUM_AGENTS+3];
   endproperty
   a_irq_unsol: assert property (p_irq_unsol) else $error("unsol event lost");

   property p_irq_rdclr;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (rd_irq && irq_ev == '0) |=> irq_st_q == CASB_IRQ_RST;
   endproperty
   a_irq_rdclr: assert property (p_irq_rdclr) else $error("event status not cleared by read");
endmodule

// ### casb_remote_model.sv
/*
 * Remote serial-bus initiator model: quadlet write pulses, packet
 * transmit reports, agent state loads and bus resets.
 * Assumes the bench calls its tasks one at a time on sys_clk_i.
 */
`timescale 1ns/1ps
module casb_remote_model (
   input  wire logic  sys_clk_i,
   output logic       bus_reset_o,
   output logic [3:0] doorbell_wr_o,
   output logic [3:0] unsol_wr_o,
   output logic       tx_done_o,
   output logic [5:0] tx_tlabel_o,
   output logic [3:0] state_valid_o,
   output logic [7:0] state_o
);
   initial
   begin
      bus_reset_o   = 1'b0;
      doorbell_wr_o = 4'h0;
      unsol_wr_o    = 4'h0;
      tx_done_o     = 1'b0;
      tx_tlabel_o   = 6'h00;
      state_valid_o = 4'h0;
      state_o       = 8'h00;
   end
   // Quadlet write to an agent doorbell
   task automatic ring(input int n);
      @(posedge sys_clk_i) doorbell_wr_o <= 4'h1 << n;
      @(posedge sys_clk_i) doorbell_wr_o <= 4'h0;
   endtask
   // Quadlet write to an unsolicited enable register
   task automatic unsol(input int n);
      @(posedge sys_clk_i) unsol_wr_o <= 4'h1 << n;
      @(posedge sys_clk_i) unsol_wr_o <= 4'h0;
   endtask
   // Packet transmitted with a given label
   task automatic send_tx(input logic [5:0] tl);
      @(posedge sys_clk_i)
      begin
         tx_done_o   <= 1'b1;
         tx_tlabel_o <= tl;
      end
      @(posedge sys_clk_i) tx_done_o <= 1'b0;
   endtask
   // Agent logic reports a new state
   task automatic load(input int n, input logic [1:0] s);
      @(posedge sys_clk_i)
      begin
         state_valid_o <= 4'h1 << n;
         state_o       <= 8'({6'h00, s}) << (2 * n);
      end
      @(posedge sys_clk_i) state_valid_o <= 4'h0;
   endtask
   task automatic bus_reset();
      @(posedge sys_clk_i) bus_reset_o <= 1'b1;
      @(posedge sys_clk_i) bus_reset_o <= 1'b0;
   endtask
endmodule

// ### tb_top.sv
/*
 * Self-checking bench for the agent status bank: register port tasks,
 * remote initiator model, interrupt checks.
 * Assumes a set mask bit lets its status bit raise the interrupt.
 */
`timescale 1ns/1ps
module tb_top
   import casb_pkg::*;
;
   logic        sys_clk_i = 1'b0;
   logic        resetn_i  = 1'b0;
   logic [7:0]  addr_i    = 8'h00;
   logic [31:0] wdata_i   = 32'h0;
   logic        wr_i      = 1'b0;
   logic        rd_i      = 1'b0;
   logic [31:0] rdata_o;
   logic        irq_o;
   logic        bus_reset_i;
   logic [3:0]  doorbell_wr_i;
   logic [3:0]  unsol_wr_i;
   logic        tx_done_i;
   logic [5:0]  tx_tlabel_i;
   logic [3:0]  state_valid_i;
   logic [7:0]  state_i;
   logic [31:0] got;
   logic [31:0] ex;
   int          fails = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   always #5 sys_clk_i = ~sys_clk_i;
   casb_bank dut_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .bus_reset_i(bus_reset_i),
      .doorbell_wr_i(doorbell_wr_i), .unsol_wr_i(unsol_wr_i), .tx_done_i(tx_done_i),
      .tx_tlabel_i(tx_tlabel_i), .state_valid_i(state_valid_i), .state_i(state_i), .irq_o(irq_o));
   casb_remote_model far_u (.sys_clk_i(sys_clk_i), .bus_reset_o(bus_reset_i),
      .doorbell_wr_o(doorbell_wr_i), .unsol_wr_o(unsol_wr_i), .tx_done_o(tx_done_i),
      .tx_tlabel_o(tx_tlabel_i), .state_valid_o(state_valid_i), .state_o(state_i));
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge sys_clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fails++;
         wrap_up();
      end
   end
   task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i)
      begin
         wr_i    <= 1'b1;
         addr_i  <= a;
         wdata_i <= d;
      end
      @(posedge sys_clk_i) wr_i <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk_i)
      begin
         rd_i   <= 1'b1;
         addr_i <= a;
      end
      @(posedge sys_clk_i) rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task automatic st(input logic [31:0] e);
      reg_rd(CASB_ADDR_STATUS, got);
      check("status", e, got);
   endtask
   task automatic irq_is(input logic e);
      repeat (2) @(posedge sys_clk_i);
      #1 check("irq", {31'h0, e}, {31'h0, irq_o});
   endtask
   initial
   begin
      repeat (5) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      st(CASB_STATUS_RST);
      reg_rd(8'h10, got);
      check("unmapped", 32'h0, got);
      for (int n = 0; n < 4; n++)
      begin
         far_u.ring(n);
         ex = 32'h04 << (8 * n);
         st(ex);
         far_u.unsol(n);
         ex = 32'h0c << (8 * n);
         st(ex);
         reg_wr(CASB_ADDR_STATUS, 32'h1f << (8 * n));
         st(32'h0f << (8 * n));
         reg_wr(CASB_ADDR_STATUS, 32'h40 << (8 * n));
         st(32'h0b << (8 * n));
         reg_wr(CASB_ADDR_STATUS, 32'h80 << (8 * n));
         st(32'h03 << (8 * n));
         reg_wr(CASB_ADDR_STATUS, 32'h20 << (8 * n));
         st(32'h00);
         far_u.load(n, CASB_ST_ACTIVE);
         st(32'h01 << (8 * n));
         far_u.load(n, CASB_ST_SUSPENDED);
         far_u.ring(n);
         st(32'h06 << (8 * n));
         far_u.bus_reset();
         st(32'h00);
      end
      for (int n = 0; n < 4; n++)
         far_u.unsol(n);
      reg_wr(CASB_ADDR_STATUS, 32'h0f0f0f0f);
      st(32'h08080808);
      reg_wr(CASB_ADDR_CTRL, 32'h002);
      far_u.send_tx(6'h3d);
      st(32'h08080808);
      reg_wr(CASB_ADDR_CTRL, 32'h802);
      reg_rd(CASB_ADDR_CTRL, got);
      check("control", 32'h802, got);
      far_u.send_tx(6'h3c);
      st(32'h08000808);
      far_u.send_tx(6'h2a);
      st(32'h08000808);
      reg_wr(CASB_ADDR_CTRL, 32'h800);
      far_u.send_tx(6'h3b);
      st(32'h08000808);
      far_u.send_tx(6'h38);
      st(32'h08000800);
      reg_rd(CASB_ADDR_IRQ_ST, got);
      check("irq status", 32'hff, got);
      irq_is(1'b0);
      far_u.ring(0);
      irq_is(1'b0);
      reg_rd(CASB_ADDR_IRQ_ST, got);
      check("irq status", 32'h01, got);
      reg_wr(CASB_ADDR_IRQ_MSK, 32'hff);
      far_u.ring(1);
      irq_is(1'b1);
      reg_rd(CASB_ADDR_IRQ_ST, got);
      check("irq status", 32'h02, got);
      irq_is(1'b0);
      wrap_up();
   end
endmodule
